// [logic/vref_ladder_defines.vh]
// constants for the reference ladder control block
// assumes a plain register port with 8-bit addresses and data
`ifndef VREF_LADDER_DEFINES_VH
`define VREF_LADDER_DEFINES_VH
// ==========================================
// register map
`define VREF_CONTROL_ADDR   8'h9f
`define VREF_CONTROL_RESET  8'h00
`define VREF_CONTROL_MASK   8'hef
// ==========================================
// field positions
`define LADDER_POWER_BIT    7
`define REF_PIN_DRIVE_BIT   6
`define RANGE_SELECT_BIT    5
`define TAP_CODE_MSB        3
`define TAP_CODE_LSB        0
// ==========================================
// ladder segment: high range starts 8 of 32 steps up
`define HIGH_RANGE_OFFSET   5'h08
`endif

// [logic/vref_ladder_control.v]
// control register and tap steering for the reference ladder
// assumes single-cycle strobes, read data wanted one cycle after read
`timescale 1ns/100ps
`include "vref_ladder_defines.vh"
module vref_ladder_control (
    input  wire       clk,
    input  wire       rst,
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    input  wire       port_a_direction_2,
    output reg        ladder_power_on,
    output reg        ref_pin_drive,
    output reg        range_select,
    output reg  [3:0] tap_code,
    output reg  [4:0] ladder_tap,
    output reg        ref_output_pin_connect
);
// ==========================================
// constants as vectors so single bits can be picked
localparam [7:0] CONTROL_RESET = `VREF_CONTROL_RESET;
localparam [7:0] CONTROL_MASK  = `VREF_CONTROL_MASK;
localparam [4:0] HIGH_OFFSET   = `HIGH_RANGE_OFFSET;

// ==========================================
// address decode
wire       hit;
wire       write_hit;
wire       read_hit;
assign hit       = (addr == `VREF_CONTROL_ADDR);
assign write_hit = wr & hit;
assign read_hit  = rd & hit;

// ==========================================
// write path: fields taken apart, spare bit dropped
wire       write_power;
wire       write_drive;
wire       write_range;
wire [3:0] write_code;
wire [7:0] next_control;
assign write_power  = wdata[`LADDER_POWER_BIT];
assign write_drive  = wdata[`REF_PIN_DRIVE_BIT];
assign write_range  = wdata[`RANGE_SELECT_BIT];
assign write_code   = wdata[`TAP_CODE_MSB:`TAP_CODE_LSB];
assign next_control = {write_power, write_drive, write_range, 1'b0, write_code}
                      & CONTROL_MASK;

// ==========================================
// control register, one cell per bit
// no sleep input, so wake-up leaves the cells alone
wire [7:0] vref_control;

// ladder power
control_bit_cell #(
    .RESET_VALUE (CONTROL_RESET[`LADDER_POWER_BIT]),
    .IMPLEMENTED (CONTROL_MASK[`LADDER_POWER_BIT])
) power_cell_i (
    .clk  (clk),
    .rst  (rst),
    .load (write_hit),
    .din  (next_control[`LADDER_POWER_BIT]),
    .dout (vref_control[`LADDER_POWER_BIT])
);

// pin drive enable
control_bit_cell #(
    .RESET_VALUE (CONTROL_RESET[`REF_PIN_DRIVE_BIT]),
    .IMPLEMENTED (CONTROL_MASK[`REF_PIN_DRIVE_BIT])
) drive_cell_i (
    .clk  (clk),
    .rst  (rst),
    .load (write_hit),
    .din  (next_control[`REF_PIN_DRIVE_BIT]),
    .dout (vref_control[`REF_PIN_DRIVE_BIT])
);

// range select
control_bit_cell #(
    .RESET_VALUE (CONTROL_RESET[`RANGE_SELECT_BIT]),
    .IMPLEMENTED (CONTROL_MASK[`RANGE_SELECT_BIT])
) range_cell_i (
    .clk  (clk),
    .rst  (rst),
    .load (write_hit),
    .din  (next_control[`RANGE_SELECT_BIT]),
    .dout (vref_control[`RANGE_SELECT_BIT])
);

// spare bit, never set
control_bit_cell #(
    .RESET_VALUE (CONTROL_RESET[`TAP_CODE_MSB + 1]),
    .IMPLEMENTED (CONTROL_MASK[`TAP_CODE_MSB + 1])
) spare_cell_i (
    .clk  (clk),
    .rst  (rst),
    .load (write_hit),
    .din  (next_control[`TAP_CODE_MSB + 1]),
    .dout (vref_control[`TAP_CODE_MSB + 1])
);

// tap code bit 3
control_bit_cell #(
    .RESET_VALUE (CONTROL_RESET[`TAP_CODE_LSB + 3]),
    .IMPLEMENTED (CONTROL_MASK[`TAP_CODE_LSB + 3])
) tap3_cell_i (
    .clk  (clk),
    .rst  (rst),
    .load (write_hit),
    .din  (next_control[`TAP_CODE_LSB + 3]),
    .dout (vref_control[`TAP_CODE_LSB + 3])
);

// tap code bit 2
control_bit_cell #(
    .RESET_VALUE (CONTROL_RESET[`TAP_CODE_LSB + 2]),
    .IMPLEMENTED (CONTROL_MASK[`TAP_CODE_LSB + 2])
) tap2_cell_i (
    .clk  (clk),
    .rst  (rst),
    .load (write_hit),
    .din  (next_control[`TAP_CODE_LSB + 2]),
    .dout (vref_control[`TAP_CODE_LSB + 2])
);

// tap code bit 1
control_bit_cell #(
    .RESET_VALUE (CONTROL_RESET[`TAP_CODE_LSB + 1]),
    .IMPLEMENTED (CONTROL_MASK[`TAP_CODE_LSB + 1])
) tap1_cell_i (
    .clk  (clk),
    .rst  (rst),
    .load (write_hit),
    .din  (next_control[`TAP_CODE_LSB + 1]),
    .dout (vref_control[`TAP_CODE_LSB + 1])
);

// tap code bit 0
control_bit_cell #(
    .RESET_VALUE (CONTROL_RESET[`TAP_CODE_LSB]),
    .IMPLEMENTED (CONTROL_MASK[`TAP_CODE_LSB])
) tap0_cell_i (
    .clk  (clk),
    .rst  (rst),
    .load (write_hit),
    .din  (next_control[`TAP_CODE_LSB]),
    .dout (vref_control[`TAP_CODE_LSB])
);

// ==========================================
// stored fields
wire       stored_power;
wire       stored_drive;
wire       stored_range;
wire       stored_spare;
wire [3:0] stored_code;
assign stored_power = vref_control[`LADDER_POWER_BIT];
assign stored_drive = vref_control[`REF_PIN_DRIVE_BIT];
assign stored_range = vref_control[`RANGE_SELECT_BIT];
assign stored_spare = vref_control[`TAP_CODE_MSB + 1];
assign stored_code  = vref_control[`TAP_CODE_MSB:`TAP_CODE_LSB];

// ==========================================
// read view: spare cell holds zero
wire [7:0] read_view;
assign read_view = {stored_power,
                    stored_drive,
                    stored_range,
                    stored_spare,
                    stored_code};

// ==========================================
// read port: data stand one cycle after the strobe, zero otherwise
always @(posedge clk) begin
    if (rst) begin
        rdata <= 8'h00;
    end else if (read_hit) begin
        rdata <= read_view & CONTROL_MASK;
    end else begin
        rdata <= 8'h00;
    end
end

// ==========================================
// ladder steering: low range index = code of 32 steps,
// high range index = 8 + code of 32 steps
wire [3:0] code_now;
wire       low_now;
wire [4:0] low_tap;
wire [4:0] high_tap;
reg  [4:0] next_tap;
assign code_now = stored_code;
assign low_now  = stored_range;
assign low_tap  = {1'b0, code_now};
assign high_tap = HIGH_OFFSET + {1'b0, code_now};
always @* begin
    next_tap = 5'h00;
    case (low_now)
        1'b1: begin
            next_tap = low_tap;
        end
        1'b0: begin
            next_tap = high_tap;
        end
        default: begin
            next_tap = 5'h00;
        end
    endcase
end

// ==========================================
// next values of the control outputs; no comparator input exists
wire       next_power;
wire       next_drive;
wire       next_range;
wire [3:0] next_code;
wire       next_connect;
assign next_power   = stored_power;
assign next_drive   = stored_drive;
assign next_range   = low_now;
assign next_code    = code_now;
assign next_connect = next_drive & port_a_direction_2;

// ==========================================
// output flops, one per output
// ladder power enable
always @(posedge clk) begin
    if (rst) begin
        ladder_power_on <= 1'b0;
    end else begin
        ladder_power_on <= next_power;
    end
end

// pin drive request
always @(posedge clk) begin
    if (rst) begin
        ref_pin_drive <= 1'b0;
    end else begin
        ref_pin_drive <= next_drive;
    end
end

// range select
always @(posedge clk) begin
    if (rst) begin
        range_select <= 1'b0;
    end else begin
        range_select <= next_range;
    end
end

// tap code
always @(posedge clk) begin
    if (rst) begin
        tap_code <= 4'h0;
    end else begin
        tap_code <= next_code;
    end
end

// ladder tap index
always @(posedge clk) begin
    if (rst) begin
        ladder_tap <= 5'h00;
    end else begin
        ladder_tap <= next_tap;
    end
end

// pin connection
always @(posedge clk) begin
    if (rst) begin
        ref_output_pin_connect <= 1'b0;
    end else begin
        ref_output_pin_connect <= next_connect;
    end
end
endmodule

// ==========================================
// one control register bit; an unimplemented bit holds RESET_VALUE in reset and zero after
module control_bit_cell #(
    parameter [0:0] RESET_VALUE = 1'b0,
    parameter [0:0] IMPLEMENTED = 1'b1
) (
    input  wire clk,
    input  wire rst,
    input  wire load,
    input  wire din,
    output reg  dout
);
always @(posedge clk) begin
    if (rst) begin
        dout <= RESET_VALUE;
    end else if (IMPLEMENTED == 1'b0) begin
        dout <= 1'b0;
    end else if (load) begin
        dout <= din;
    end
end
endmodule

// [tb/vref_ladder_control_assertions.sv]
// concurrent checks on the reference ladder control ports
// assumes it is bound into the control block and sees its ports only
`timescale 1ns/100ps
module vref_chk(input wire clk,rst,wr,rd,ref_pin_drive,range_select,
input wire ladder_power_on,ref_output_pin_connect,port_a_direction_2,
input wire[7:0]addr,wdata,rdata,input wire[3:0]tap_code,input wire[4:0]ladder_tap);
wire w=wr&&addr==8'h9f;
default clocking@(posedge clk);endclocking
default disable iff(rst);
property p_rs;$fell(rst)|->!{ladder_power_on,ref_pin_drive,range_select,tap_code};endproperty
a_rs:assert property(p_rs)else $error("rs");
property p_cn;!$past(rst)|->ref_output_pin_connect==(ref_pin_drive&&$past(port_a_direction_2));
endproperty
a_cn:assert property(p_cn)else $error("cn");
property p_oe;w|->##2 ref_pin_drive==$past(wdata[6],2);endproperty
a_oe:assert property(p_oe)else $error("oe");
property p_rg;w|->##2 range_select==$past(wdata[5],2);endproperty
a_rg:assert property(p_rg)else $error("rg");
property p_tc;w|->##2 tap_code==$past(wdata[3:0],2);endproperty
a_tc:assert property(p_tc)else $error("tc");
property p_lo;range_select|->ladder_tap==tap_code;endproperty
a_lo:assert property(p_lo)else $error("lo");
property p_hi;!range_select&&!$past(rst)|->ladder_tap==tap_code+8;endproperty
a_hi:assert property(p_hi)else $error("hi");
property p_b4;rd|=>!rdata[4];endproperty
a_b4:assert property(p_b4)else $error("b4");
property p_rd;rd&&addr==8'h9f|=>rdata[3:0]==tap_code;endproperty
a_rd:assert property(p_rd)else $error("rd");
cover property(w##2 range_select);
cover property(w##2 !range_select);
cover property(rd##1 rdata[7]);
endmodule
bind vref_ladder_control vref_chk vref_chk_i(.*);

// [tb/vref_ladder_control_test.sv]
// testbench for the reference ladder control block
// drives the register port and the direction pin itself
`timescale 1ns/100ps
module vref_ladder_control_test;
reg        clk                = 1'b0;
reg        rst                = 1'b1;
reg        wr                 = 1'b0;
reg        rd                 = 1'b0;
reg        port_a_direction_2 = 1'b0;
reg  [7:0] addr               = 8'h00;
reg  [7:0] wdata              = 8'h00;
wire [7:0] rdata;
wire [4:0] ladder_tap;
wire [3:0] tap_code;
wire       ladder_power_on;
wire       ref_pin_drive;
wire       range_select;
wire       ref_output_pin_connect;
integer    errors             = 0;
integer    n_tests            = 0;
integer    i;
reg  [7:0] value;
vref_ladder_control vref_ladder_control_i (
    .clk                    (clk),
    .rst                    (rst),
    .addr                   (addr),
    .wdata                  (wdata),
    .wr                     (wr),
    .rd                     (rd),
    .rdata                  (rdata),
    .port_a_direction_2     (port_a_direction_2),
    .ladder_power_on        (ladder_power_on),
    .ref_pin_drive          (ref_pin_drive),
    .range_select           (range_select),
    .tap_code               (tap_code),
    .ladder_tap             (ladder_tap),
    .ref_output_pin_connect (ref_output_pin_connect)
);
always #2.5 clk = ~clk;
// ==========================================
// compare and count
task chk;
    input [7:0]      seen;
    input [7:0]      expected;
    input [8*12-1:0] msg;
    begin
        n_tests = n_tests + 1;
        if (seen !== expected) begin
            errors = errors + 1;
            $display("wrong value at %0t: %0s seen %h expected %h", $time, msg, seen, expected);
        end
    end
endtask
// ==========================================
// one-cycle write strobe
task write_reg;
    input [7:0] a;
    input [7:0] d;
    begin
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    end
endtask
// one-cycle read strobe, data looked at mid-cycle while they stand
task read_chk;
    input [7:0]      a;
    input [7:0]      expected;
    input [8*12-1:0] msg;
    begin
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        chk(rdata, expected, msg);
    end
endtask
// outputs follow the register one edge later
task settle;
    begin
        repeat (2) @(negedge clk);
    end
endtask
// ==========================================
// verdict
task complete_run;
    begin
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    end
endtask
// ==========================================
// scenarios
initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 32; i = i + 1) begin
        value = {i[1], i[2], i[4], 1'b1, i[3:0]};
        @(posedge clk);
        port_a_direction_2 <= i[0];
        write_reg(8'h9f, value);
        settle;
        read_chk(8'h9f, value & 8'hef, "readback");
        chk({7'h00, ladder_power_on}, {7'h00, i[1]}, "power");
        chk({7'h00, ref_pin_drive}, {7'h00, i[2]}, "pin drive");
        chk({7'h00, range_select}, {7'h00, i[4]}, "range");
        chk({4'h0, tap_code}, {4'h0, i[3:0]}, "tap code");
        chk({3'h0, ladder_tap}, i[4] ? {4'h0, i[3:0]} : 8'h08 + {4'h0, i[3:0]}, "tap");
        chk({7'h00, ref_output_pin_connect}, {7'h00, i[0] & i[2]}, "connect");
    end
    read_chk(8'h9e, 8'h00, "unmapped");
    write_reg(8'h9f, 8'hff);
    settle;
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({7'h00, ladder_power_on}, 8'h00, "rst power");
    chk({7'h00, ref_pin_drive}, 8'h00, "rst drive");
    chk({7'h00, range_select}, 8'h00, "rst range");
    chk({4'h0, tap_code}, 8'h00, "rst code");
    read_chk(8'h9f, 8'h00, "rst read");
    write_reg(8'h9f, 8'he6);
    write_reg(8'h9f, 8'h06);
    settle;
    chk({7'h00, ladder_power_on}, 8'h00, "power down");
    complete_run;
end
endmodule
